// ### src/array_cells.sv
// Byte-wide cell array with a registered read port and program/erase write port.
`timescale 1ns/1ps
module array_cells (
    // Clock
    input  wire logic       i_mclk,
    // Read port
    input  wire logic       i_rd_en,
    input  wire logic [8:0] i_rd_addr,
    output logic      [7:0] o_rd_data,
    // Write port
    input  wire logic       i_wr_en,
    input  wire logic       i_wr_erase,
    input  wire logic [8:0] i_wr_addr,
    input  wire logic [7:0] i_wr_data
);
    import array_seq_pkg::*;

    logic [7:0] cells [0:511];

    // A fresh array reads as all ones.
    initial begin
        for (int i = 0; i < 512; i++) begin
            cells[i] = ERASED_BYTE;
        end
    end

    // Programming only clears bits; erasing sets the whole byte.
    always_ff @(posedge i_mclk) begin
        if (i_wr_en) begin
            if (i_wr_erase) begin
                cells[i_wr_addr] <= ERASED_BYTE;
            end else begin
                cells[i_wr_addr] <= cells[i_wr_addr] & i_wr_data;
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rd_en) begin
            o_rd_data <= cells[i_rd_addr];
        end
    end

endmodule

// ### src/array_seq_pkg.sv
// Shared constants for the nonvolatile array program/erase sequencer.
package array_seq_pkg;

    // APB register map (byte addresses); array words occupy 0x000-0x7FC.
    localparam logic [11:0] ADDR_PROGRAM_CONTROL    = 12'h800;
    localparam logic [11:0] ADDR_PROTECTION_CONFIG  = 12'h804;
    localparam logic [11:0] ADDR_NV_PROTECTION      = 12'h808;
    localparam logic [11:0] ADDR_TIMEBASE_DIVIDER   = 12'h80C;
    localparam int          ARRAY_SELECT_BIT        = 11;

    // Control register field positions.
    localparam int CTL_SPARE     = 7;
    localparam int CTL_POWER_OFF = 5;
    localparam int CTL_MODE_HI   = 4;
    localparam int CTL_MODE_LO   = 3;
    localparam int CTL_LATCH     = 2;
    localparam int CTL_AUTO      = 1;
    localparam int CTL_HV        = 0;

    // Protection config field positions.
    localparam int PROT_SECURITY_DISABLE = 4;

    // Operation mode encodings.
    localparam logic [1:0] MODE_BYTE_PROGRAM = 2'h0;
    localparam logic [1:0] MODE_BYTE_ERASE   = 2'h1;
    localparam logic [1:0] MODE_BLOCK_ERASE  = 2'h2;
    localparam logic [1:0] MODE_BULK_ERASE   = 2'h3;

    // Reset and fresh-array values.
    localparam logic [7:0] ERASED_BYTE     = 8'hFF;
    localparam logic [7:0] NVCFG_FACTORY   = 8'h10;
    localparam logic [7:0] CONTROL_RESET   = 8'h00;
    localparam logic [8:0] LAST_ARRAY_BYTE = 9'h1FF;
    localparam logic [4:0] SECURE_ROW      = 5'h0F;

    // Timebase: 35 us derived from the 50 ns system clock.
    localparam int MCLK_PERIOD_NS = 50;
    localparam int TIMEBASE_NS    = 35000;
    localparam logic [10:0] TIMEBASE_DIV_RESET =
        11'((TIMEBASE_NS + MCLK_PERIOD_NS / 2) / MCLK_PERIOD_NS);

    // Nominal operation times in microseconds; ticks are rounded down.
    localparam int BYTE_PROGRAM_TIME_US = 10000;
    localparam int BYTE_ERASE_TIME_US   = 10000;
    localparam int BLOCK_ERASE_TIME_US  = 10000;
    localparam int BULK_ERASE_TIME_US   = 10000;
    localparam logic [11:0] PROGRAM_TICKS     = 12'(BYTE_PROGRAM_TIME_US * 1000 / TIMEBASE_NS);
    localparam logic [11:0] BYTE_ERASE_TICKS  = 12'(BYTE_ERASE_TIME_US * 1000 / TIMEBASE_NS);
    localparam logic [11:0] BLOCK_ERASE_TICKS = 12'(BLOCK_ERASE_TIME_US * 1000 / TIMEBASE_NS);
    localparam logic [11:0] BULK_ERASE_TICKS  = 12'(BULK_ERASE_TIME_US * 1000 / TIMEBASE_NS);

endpackage

// ### src/array_sequencer.sv
// APB-controlled program/erase sequencer for the 512-byte nonvolatile array.
//
// Summary of operation
// - Erased cells and fresh array read ones.
// - Program only clears bits within one byte.
// - Erase sets bits, byte up to array.
// - Protected locations ignore program and erase.
// - Latch captures valid array writes; last wins.
// - Latched reads return data, reload address.
// - Enable needs latch and address; mode frozen.
// - Self-clear timer ends cycle, clears enable.
// - Latch cannot clear while enable set.
// - Block and bulk erase skip config.
// - Mode bits select operation; reset clears.
// - Power-off bit disables array accesses.
// - Enable drives pump only when armed.
// - Wait mode leaves sequence running.
// - Stop halts, drops voltage, restarts afterwards.
// - Protection config loads from nonvolatile copy.
// - Four bits protect 128-byte quarters.
// - Security blocks bulk/block, row 0x0F (bytes 0xF0-0xFF), config.
// - Timer runs from 35 us timebase.
`timescale 1ns/1ps
module array_sequencer (
    // Clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_reset,
    // APB slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // System power mode
    input  wire logic        i_stop_mode,
    // Charge pump
    output logic             o_charge_pump_on
);
    import array_seq_pkg::*;

    typedef enum logic [1:0] {
        st_idle,
        st_timing,
        st_walk,
        st_done
    } seq_state_type;

    // Control register fields.
    logic        spare_bit;
    logic        array_power_off;
    logic [1:0]  op_mode;
    logic        bus_latch_enable;
    logic        self_clear;
    logic        hv_operation_enable;

    // Latched target and configuration.
    logic [8:0]  latched_addr;
    logic        latched_is_nv;
    logic        addr_valid;
    logic [7:0]  latched_data;
    logic [7:0]  nonvolatile_protection_config = NVCFG_FACTORY;
    logic [7:0]  array_protection_config;
    logic [10:0] timebase_divider;

    // Sequencer state.
    seq_state_type state;
    logic [11:0] ticks;
    logic [8:0]  walk_addr;
    logic [8:0]  walk_end;
    logic        cycle_failed;
    logic        resume_pending;
    logic        tick;

    // Memory ports.
    logic [7:0]  mem_rd_data;
    logic        mem_wr_en;

    // Decode.
    logic        access;
    logic        wr_access;
    logic        rd_access;
    logic        hit_array;
    logic        hit_nv;
    logic        hit_target;
    logic        hit_control;
    logic        hit_prot;
    logic        hit_div;
    logic        hit_any;
    logic        array_blocked;
    logic        security_on;
    logic [11:0] need_ticks;
    logic        op_allowed;
    logic        walk_last;
    logic        auto_clear;
    logic        walk_byte_ok;

    assign access      = i_psel && i_penable && o_pready;
    assign wr_access   = access && i_pwrite;
    assign rd_access   = access && !i_pwrite;
    assign hit_array   = !i_paddr[ARRAY_SELECT_BIT];
    assign hit_nv      = i_paddr == ADDR_NV_PROTECTION;
    assign hit_target  = hit_array || hit_nv;
    assign hit_control = i_paddr == ADDR_PROGRAM_CONTROL;
    assign hit_prot    = i_paddr == ADDR_PROTECTION_CONFIG;
    assign hit_div     = i_paddr == ADDR_TIMEBASE_DIVIDER;
    assign hit_any     = hit_target || hit_control || hit_prot || hit_div;
    // After a stop exit the array stays closed until the restarted cycle ends.
    assign array_blocked = resume_pending && hit_target;
    assign security_on   = !array_protection_config[PROT_SECURITY_DISABLE];

    // Operation time for the selected mode.
    always_comb begin
        case (op_mode)
            MODE_BYTE_PROGRAM: need_ticks = PROGRAM_TICKS;
            MODE_BYTE_ERASE:   need_ticks = BYTE_ERASE_TICKS;
            MODE_BLOCK_ERASE:  need_ticks = BLOCK_ERASE_TICKS;
            default:           need_ticks = BULK_ERASE_TICKS;
        endcase
    end

    // Whole-operation permission; per-byte protection is checked in the walk.
    always_comb begin
        op_allowed = 1'b1;
        if (security_on && (op_mode == MODE_BLOCK_ERASE || op_mode == MODE_BULK_ERASE)) begin
            op_allowed = 1'b0;
        end
        if (latched_is_nv && (op_mode == MODE_BLOCK_ERASE || op_mode == MODE_BULK_ERASE)) begin
            op_allowed = 1'b0;
        end
        if (latched_is_nv && security_on) begin
            op_allowed = 1'b0;
        end
    end

    // Per-byte protection of array locations.
    always_comb begin
        walk_byte_ok = !array_protection_config[walk_addr[8:7]];
        if (security_on && walk_addr[8:4] == SECURE_ROW) begin
            walk_byte_ok = 1'b0;
        end
    end

    assign walk_last  = walk_addr == walk_end;
    assign auto_clear = state == st_walk && walk_last && self_clear;
    // Block and bulk walks never touch the config byte; protected bytes are skipped.
    assign mem_wr_en  = state == st_walk && !latched_is_nv && op_allowed && !cycle_failed
                        && walk_byte_ok;

    // Control register.
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            spare_bit           <= CONTROL_RESET[CTL_SPARE];
            array_power_off     <= CONTROL_RESET[CTL_POWER_OFF];
            op_mode             <= CONTROL_RESET[CTL_MODE_HI:CTL_MODE_LO];
            bus_latch_enable    <= CONTROL_RESET[CTL_LATCH];
            self_clear          <= CONTROL_RESET[CTL_AUTO];
            hv_operation_enable <= CONTROL_RESET[CTL_HV];
        end else begin
            if (wr_access && hit_control) begin
                if (!bus_latch_enable || addr_valid) begin
                    spare_bit       <= i_pwdata[CTL_SPARE];
                    array_power_off <= i_pwdata[CTL_POWER_OFF];
                    self_clear      <= i_pwdata[CTL_AUTO];
                    if (!hv_operation_enable) begin
                        op_mode <= i_pwdata[CTL_MODE_HI:CTL_MODE_LO];
                    end
                    if (i_pwdata[CTL_HV] && bus_latch_enable && addr_valid) begin
                        hv_operation_enable <= 1'b1;
                    end else if (!i_pwdata[CTL_HV]) begin
                        hv_operation_enable <= 1'b0;
                    end
                end
                // Clearing both bits at once drops only the enable, giving the
                // high voltage time to decay before the buses are released.
                if (!hv_operation_enable) begin
                    bus_latch_enable <= i_pwdata[CTL_LATCH];
                end
            end
            if (auto_clear) begin
                hv_operation_enable <= 1'b0;
            end
        end
    end

    // Address and data latch.
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            latched_addr  <= 9'h000;
            latched_is_nv <= 1'b0;
            latched_data  <= 8'h00;
            addr_valid    <= 1'b0;
            cycle_failed  <= 1'b0;
        end else begin
            // Clearing first lets a same-cycle spoiling access still win.
            if (state == st_idle && hv_operation_enable) begin
                cycle_failed <= 1'b0;
            end
            if (!bus_latch_enable) begin
                addr_valid <= 1'b0;
            end else if (access && hit_target && !array_blocked && !array_power_off) begin
                if (hv_operation_enable) begin
                    // Touching the array mid-cycle spoils it; nothing gets written.
                    cycle_failed <= 1'b1;
                end else begin
                    latched_addr  <= i_paddr[10:2];
                    latched_is_nv <= hit_nv;
                    addr_valid    <= 1'b1;
                    if (i_pwrite) begin
                        latched_data <= i_pwdata[7:0];
                    end
                end
            end
        end
    end

    // Timebase divider register, locked while the latch is set.
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            timebase_divider <= TIMEBASE_DIV_RESET;
        end else if (wr_access && hit_div && !bus_latch_enable) begin
            timebase_divider <= i_pwdata[10:0];
        end
    end

    // Protection config follows the nonvolatile copy at reset and on its read.
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            array_protection_config <= nonvolatile_protection_config;
        end else if (rd_access && hit_nv && !bus_latch_enable) begin
            array_protection_config <= nonvolatile_protection_config;
        end
    end

    // Nonvolatile config byte: only a byte program or byte erase aimed at it.
    always_ff @(posedge i_mclk) begin
        if (state == st_walk && latched_is_nv && op_allowed && !cycle_failed) begin
            if (op_mode == MODE_BYTE_ERASE) begin
                nonvolatile_protection_config <= ERASED_BYTE;
            end else begin
                nonvolatile_protection_config <= nonvolatile_protection_config & latched_data;
            end
        end
    end

    array_timebase u_timebase (
        .i_mclk    (i_mclk),
        .i_reset   (i_reset),
        .i_run     (state == st_timing && !i_stop_mode),
        .i_divisor (timebase_divider),
        .o_tick    (tick)
    );

    // Sequencer: wait mode has no input here, so a running cycle simply continues.
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            state          <= st_idle;
            ticks          <= 12'h000;
            walk_addr      <= 9'h000;
            walk_end       <= 9'h000;
            resume_pending <= 1'b0;
        end else begin
            case (state)
                st_idle: begin
                    ticks <= 12'h000;
                    if (hv_operation_enable) begin
                        state <= st_timing;
                    end
                end
                st_timing: begin
                    if (!hv_operation_enable) begin
                        state          <= st_idle;
                        resume_pending <= 1'b0;
                    end else if (i_stop_mode) begin
                        ticks          <= 12'h000;
                        resume_pending <= 1'b1;
                    end else if (tick) begin
                        if (12'(ticks + 12'h001) >= need_ticks) begin
                            state <= st_walk;
                            case (op_mode)
                                MODE_BLOCK_ERASE: begin
                                    walk_addr <= {latched_addr[8:7], 7'h00};
                                    walk_end  <= {latched_addr[8:7], 7'h7F};
                                end
                                MODE_BULK_ERASE: begin
                                    walk_addr <= 9'h000;
                                    walk_end  <= LAST_ARRAY_BYTE;
                                end
                                default: begin
                                    walk_addr <= latched_addr;
                                    walk_end  <= latched_addr;
                                end
                            endcase
                        end else begin
                            ticks <= 12'(ticks + 12'h001);
                        end
                    end
                end
                st_walk: begin
                    walk_addr <= 9'(walk_addr + 9'h001);
                    if (walk_last) begin
                        state          <= st_done;
                        resume_pending <= 1'b0;
                    end
                end
                st_done: begin
                    if (!hv_operation_enable) begin
                        state <= st_idle;
                    end
                end
                default: begin
                    state <= st_idle;
                end
            endcase
        end
    end

    array_cells u_cells (
        .i_mclk     (i_mclk),
        .i_rd_en    (i_psel && !i_penable),
        .i_rd_addr  (i_paddr[10:2]),
        .o_rd_data  (mem_rd_data),
        .i_wr_en    (mem_wr_en),
        .i_wr_erase (op_mode != MODE_BYTE_PROGRAM),
        .i_wr_addr  (walk_addr),
        .i_wr_data  (latched_data)
    );

    // Pump runs only while armed, timing or walking, and out of stop.
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_charge_pump_on <= 1'b0;
        end else begin
            o_charge_pump_on <= hv_operation_enable && bus_latch_enable && addr_valid
                                && (state == st_timing || state == st_walk) && !i_stop_mode;
        end
    end

    // APB answer: one wait state so the registered array read can settle.
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_pready  <= 1'b0;
            o_prdata  <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end else if (i_psel && i_penable && !o_pready) begin
            o_pready  <= 1'b1;
            o_pslverr <= !hit_any || array_blocked;
            o_prdata  <= 32'h0000_0000;
            if (!i_pwrite && !array_blocked) begin
                if (hit_target && array_power_off) begin
                    o_prdata <= 32'h0000_0000;
                end else if (hit_target && bus_latch_enable) begin
                    o_prdata <= {24'h000000, latched_data};
                end else if (hit_array) begin
                    o_prdata <= {24'h000000, mem_rd_data};
                end else if (hit_nv) begin
                    o_prdata <= {24'h000000, nonvolatile_protection_config};
                end else if (hit_control) begin
                    o_prdata <= {24'h000000, spare_bit, 1'b0, array_power_off, op_mode,
                                 bus_latch_enable, self_clear, hv_operation_enable};
                end else if (hit_prot) begin
                    o_prdata <= {24'h000000, array_protection_config};
                end else if (hit_div) begin
                    o_prdata <= {21'h00000, timebase_divider};
                end
            end
        end else begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
        end
    end

endmodule

// ### src/array_timebase.sv
// Divider that turns the system clock into the 35 us timebase tick.
`timescale 1ns/1ps
module array_timebase (
    // Clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_reset,
    // Control
    input  wire logic        i_run,
    input  wire logic [10:0] i_divisor,
    // Tick
    output logic             o_tick
);
    logic [10:0] count;

    // Restarting on run keeps the first tick a full period after the start.
    always_ff @(posedge i_mclk) begin
        if (i_reset || !i_run) begin
            count  <= 11'h000;
            o_tick <= 1'b0;
        end else if (11'(count + 11'h001) >= i_divisor) begin
            count  <= 11'h000;
            o_tick <= 1'b1;
        end else begin
            count  <= 11'(count + 11'h001);
            o_tick <= 1'b0;
        end
    end

endmodule

// ### verif/apb_host_model.sv
// Processor-side bus master that issues register and array accesses.
`timescale 1ns/1ps
module apb_host_model (
    // Clock
    input  wire logic        i_mclk,
    // Request
    output logic             o_psel,
    output logic             o_penable,
    output logic             o_pwrite,
    output logic      [11:0] o_paddr,
    output logic      [31:0] o_pwdata,
    // Answer
    input  wire logic [31:0] i_prdata,
    input  wire logic        i_pready,
    input  wire logic        i_pslverr
);
    initial begin
        o_psel = 1'b0;
        o_penable = 1'b0;
        o_pwrite = 1'b0;
        o_paddr = 12'h000;
        o_pwdata = 32'h0;
    end
    // The request is held until ready is seen; t stays high if no answer comes.
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e, output logic t);
        t = 1'b1;
        @(posedge i_mclk);
        o_psel <= 1'b1;
        o_penable <= 1'b0;
        o_pwrite <= w;
        o_paddr <= a;
        o_pwdata <= d;
        @(posedge i_mclk);
        o_penable <= 1'b1;
        for (int i = 0; i < 64 && t; i++) begin
            @(posedge i_mclk);
            if (i_pready === 1'b1) begin
                r = i_prdata;
                e = i_pslverr;
                t = 1'b0;
            end
        end
        o_psel <= 1'b0;
        o_penable <= 1'b0;
        // Released lines toggle so no stale value can be mistaken for a request.
        o_paddr <= ~a;
        o_pwdata <= ~d;
    endtask
endmodule

// ### verif/array_sequencer_sva.sv
// Bus handshake and charge pump assertions for the program/erase sequencer.
`timescale 1ns/1ps
module array_sequencer_sva (
    // Clock and reset
    input wire logic        i_mclk,
    input wire logic        i_reset,
    // APB
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    // Power mode and pump
    input wire logic        i_stop_mode,
    input wire logic        o_charge_pump_on
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_reset);
    AST_READY_LATENCY: assert property (i_psel && !i_penable |-> ##2 o_pready)
        else $error("ready not two edges after setup");
    AST_READY_PULSE: assert property (o_pready |=> !o_pready)
        else $error("ready held longer than one cycle");
    AST_READY_CAUSE: assert property (o_pready |-> $past(i_psel && i_penable))
        else $error("ready without an access phase");
    AST_ERR_WITH_READY: assert property (o_pslverr |-> o_pready)
        else $error("error flag outside a response");
    AST_UNMAPPED_ERR: assert property (o_pready && i_paddr > 12'h80C |-> o_pslverr)
        else $error("unmapped address answered without error");
    AST_UPPER_ZERO: assert property (o_pready |-> o_prdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    AST_STOP_PUMP_OFF: assert property (i_stop_mode |=> !o_charge_pump_on)
        else $error("pump on during stop");
    AST_RESET_OUTPUTS: assert property (disable iff (1'b0) i_reset |=> !o_charge_pump_on && !o_pready)
        else $error("outputs active after reset");
endmodule
bind array_sequencer array_sequencer_sva u_sva (
    .i_mclk(i_mclk), .i_reset(i_reset), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_stop_mode(i_stop_mode),
    .o_charge_pump_on(o_charge_pump_on)
);

// ### verif/array_sequencer_tb.sv
// Directed bench for the nonvolatile array program/erase sequencer.
`timescale 1ns/1ps
module array_sequencer_tb;
    import array_seq_pkg::*;
    typedef struct {logic w; logic [11:0] a; logic [7:0] d; logic [7:0] x; logic e;} row_type;
    localparam logic [11:0] CTL = ADDR_PROGRAM_CONTROL;
    localparam logic [11:0] NV = ADDR_NV_PROTECTION;
    logic        i_mclk = 1'b0;
    logic        i_reset = 1'b1;
    logic        i_stop_mode = 1'b0;
    logic        psel, penable, pwrite, pready, pslverr, pump, er, to;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int          failures = 0;
    int          samples_checked = 0;
    row_type     rows[13] = '{'{0, ADDR_PROTECTION_CONFIG, 0, NVCFG_FACTORY, 0},
        '{0, CTL, 0, CONTROL_RESET, 0}, '{0, 12'h000, 0, ERASED_BYTE, 0},
        '{0, 12'h7FC, 0, ERASED_BYTE, 0}, '{0, 12'h810, 0, 8'h00, 1},
        '{1, 12'h004, 8'h00, 0, 0}, '{0, 12'h004, 0, ERASED_BYTE, 0},
        '{1, ADDR_TIMEBASE_DIVIDER, 8'h02, 0, 0}, '{0, ADDR_TIMEBASE_DIVIDER, 0, 8'h02, 0},
        '{1, CTL, 8'hA0, 0, 0}, '{0, 12'h000, 0, 8'h00, 0}, '{0, CTL, 0, 8'hA0, 0},
        '{1, CTL, 8'h00, 0, 0}};
    initial forever #25 i_mclk = ~i_mclk;
    array_sequencer dut (.i_mclk(i_mclk), .i_reset(i_reset), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_stop_mode(i_stop_mode), .o_charge_pump_on(pump));
    apb_host_model mst (.i_mclk(i_mclk), .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite),
        .o_paddr(paddr), .o_pwdata(pwdata), .i_prdata(prdata), .i_pready(pready), .i_pslverr(pslverr));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wrap_up;
        $display("checked %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task bus(input logic w, input logic [11:0] a, input logic [7:0] d);
        mst.xfer(w, a, {24'h0, d}, rd, er, to);
        if (to) begin
            failures++;
            wrap_up();
        end
    endtask
    task rdchk(input logic [11:0] a, input logic [7:0] x);
        bus(0, a, 8'h00);
        chk(rd, {24'h0, x});
    endtask
    // Only the control register is read while the enable bit may be set.
    task poll;
        for (int i = 0; i < 2000; i++) begin
            bus(0, CTL, 8'h00);
            if (rd[0] === 1'b0) return;
        end
        failures++;
        wrap_up();
    endtask
    task op(input logic [1:0] m, input logic [11:0] a, input logic [7:0] d);
        bus(1, CTL, {3'h0, m, 3'h4});
        bus(1, a, d);
        bus(1, CTL, {3'h0, m, 3'h7});
        poll();
        bus(1, CTL, 8'h00);
    endtask
    initial begin
        repeat (12) @(posedge i_mclk);
        i_reset <= 1'b0;
        foreach (rows[i]) begin
            bus(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) chk(rd, {24'h0, rows[i].x});
            chk({31'h0, er}, {31'h0, rows[i].e});
        end
        $display("register table done");
        bus(1, CTL, 8'h07);
        rdchk(CTL, 8'h06);
        bus(1, 12'h014, 8'h33);
        bus(1, 12'h014, 8'h5A);
        rdchk(12'h018, 8'h5A);
        bus(1, CTL, 8'h07);
        repeat (3) @(posedge i_mclk);
        chk({31'h0, pump}, 32'h1);
        poll();
        bus(1, CTL, 8'h00);
        rdchk(12'h018, 8'h5A);
        rdchk(12'h014, 8'hFF);
        bus(1, CTL, 8'h04);
        bus(1, 12'h018, 8'h0F);
        bus(1, CTL, 8'h05);
        repeat (1200) @(posedge i_mclk);
        bus(1, CTL, 8'h00);
        rdchk(CTL, 8'h04);
        bus(1, CTL, 8'h00);
        rdchk(12'h018, 8'h0A);
        $display("program tests done");
        bus(1, CTL, 8'h0C);
        bus(1, 12'h018, 8'h00);
        bus(1, CTL, 8'h0F);
        bus(1, CTL, 8'h1F);
        rdchk(CTL, 8'h0F);
        i_stop_mode <= 1'b1;
        repeat (20) @(posedge i_mclk);
        chk({31'h0, pump}, 32'h0);
        i_stop_mode <= 1'b0;
        bus(0, 12'h018, 8'h00);
        chk({31'h0, er}, 32'h1);
        poll();
        bus(1, CTL, 8'h00);
        rdchk(12'h018, 8'hFF);
        $display("stop test done");
        op(MODE_BYTE_PROGRAM, 12'h200, 8'h00);
        op(MODE_BYTE_ERASE, NV, 8'h00);
        op(MODE_BYTE_PROGRAM, NV, 8'hF1);
        rdchk(NV, 8'hF1);
        rdchk(ADDR_PROTECTION_CONFIG, 8'hF1);
        op(MODE_BYTE_PROGRAM, 12'h018, 8'h00);
        rdchk(12'h018, 8'hFF);
        op(MODE_BULK_ERASE, 12'h400, 8'h00);
        rdchk(12'h200, 8'hFF);
        rdchk(NV, 8'hF1);
        op(MODE_BYTE_PROGRAM, 12'h200, 8'h00);
        op(MODE_BYTE_PROGRAM, 12'h400, 8'h00);
        op(MODE_BLOCK_ERASE, 12'h3FC, 8'h00);
        rdchk(12'h200, 8'hFF);
        rdchk(12'h400, 8'h00);
        op(MODE_BYTE_PROGRAM, NV, 8'hE1);
        rdchk(NV, 8'hE1);
        op(MODE_BYTE_PROGRAM, 12'h200, 8'h00);
        op(MODE_BYTE_PROGRAM, 12'h3C0, 8'h00);
        op(MODE_BULK_ERASE, 12'h400, 8'h00);
        rdchk(12'h3C0, 8'hFF);
        rdchk(12'h200, 8'h00);
        rdchk(12'h400, 8'h00);
        op(MODE_BYTE_ERASE, NV, 8'h00);
        rdchk(NV, 8'hE1);
        $display("protection tests done");
        bus(1, CTL, 8'h04);
        bus(1, 12'h204, 8'h00);
        bus(1, CTL, 8'h07);
        i_reset <= 1'b1;
        repeat (12) @(posedge i_mclk);
        i_reset <= 1'b0;
        chk({31'h0, pump}, 32'h0);
        rdchk(CTL, CONTROL_RESET);
        rdchk(ADDR_PROTECTION_CONFIG, 8'hE1);
        rdchk(12'h204, 8'hFF);
        $display("reset test done");
        wrap_up();
    end
endmodule
